// ==== core/wtpu_pkg.sv ====
package wtpu_pkg;
	// word and address widths of the data memory
	localparam int WTPU_DATA_W = 16;
	localparam int WTPU_ADDR_W = 12;
	localparam int WTPU_LEN_W = 8;
	localparam int WTPU_MEM_WORDS = 4096;
	localparam int WTPU_FIFO_DEPTH = 8;
	// counter word sits at the base, entry one right after it
	localparam logic [WTPU_ADDR_W-1:0] WTPU_CNT_OFS = 12'h000;
	localparam logic [WTPU_ADDR_W-1:0] WTPU_TOP_OFS = 12'h001;
	localparam logic [WTPU_ADDR_W-1:0] WTPU_ADDR_STEP = 12'h001;
	localparam logic [WTPU_DATA_W-1:0] WTPU_CNT_STEP = 16'h0001;
	localparam logic [WTPU_DATA_W-1:0] WTPU_CNT_EMPTY = 16'h0000;

	// table operation selector
	typedef enum logic {
		WTPU_OP_POP,
		WTPU_OP_PUSH
	} wtpu_op_t;

	// engine states
	typedef enum logic [2:0] {
		WTPU_IDLE,
		WTPU_FETCH,
		WTPU_CHECK,
		WTPU_SHIFT,
		WTPU_EMIT,
		WTPU_HOLD,
		WTPU_COUNT
	} wtpu_state_t;

	// one operation as handed over by the scan sequencer
	typedef struct packed {
		wtpu_op_t op;
		logic [WTPU_LEN_W-1:0] len;
		logic [WTPU_ADDR_W-1:0] base;
		logic [WTPU_ADDR_W-1:0] arg;
	} wtpu_req_t;

	// whole registered state of the engine
	typedef struct packed {
		wtpu_state_t state;
		wtpu_req_t req;
		logic [WTPU_DATA_W-1:0] cnt;
		logic [WTPU_ADDR_W-1:0] idx;
		logic [WTPU_DATA_W-1:0] word;
		logic [WTPU_DATA_W-1:0] rdata;
		logic flag;
		logic busy;
		logic done;
		logic emit_v;
	} wtpu_reg_t;
endpackage

// ==== core/wtpu_fifo.sv ====
`timescale 1ns/1ps
module wtpu_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	// pointers and fill level
	typedef struct packed {
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] level;
	} wtpu_fifo_st_t;

	wtpu_fifo_st_t r, next_r; // state and its next value
	logic [WIDTH-1:0] store [DEPTH]; // word storage
	logic push; // word accepted this cycle
	logic pop; // word drained this cycle

	// handshake terms from the fill level
	assign in_ready_o = (r.level != FULL);
	assign out_valid_o = (r.level != '0);
	assign out_data_o = store[r.rd];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// pointer and level update
	always_comb begin
		next_r = r;
		if (push) begin
			next_r.wr = (r.wr == LAST) ? '0 : r.wr + PW'(1);
		end
		if (pop) begin
			next_r.rd = (r.rd == LAST) ? '0 : r.rd + PW'(1);
		end
		if (push && !pop) begin
			next_r.level = r.level + CW'(1);
		end else if (pop && !push) begin
			next_r.level = r.level - CW'(1);
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// storage write, no reset needed
	always_ff @(posedge clk_i) begin
		if (push) begin
			store[r.wr] <= in_data_i;
		end
	end
endmodule // wtpu_fifo

// ==== core/wtpu_unit.sv ====
`timescale 1ns/1ps
// Behaviour
// - pop copies top entry, shifts rest up
// - base word is counter, data follows
// - each accepted pop decrements counter by one
// - bad pop counter: no move, flag set
// - one operation per execute strobe
// - pop flags counter equal zero
// - flag cleared by next op or scan end
// - push shifts down, writes top entry
// - each accepted push increments counter by one
// - push flags counter equal length
// - push only while counter below length
// - entries one to N take part
// - pop leaves entries beyond counter alone
module wtpu_unit import wtpu_pkg::*; #(
	parameter int MEM_WORDS = WTPU_MEM_WORDS,
	parameter int FIFO_DEPTH = WTPU_FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic exec_i,
	input wire wtpu_req_t req_i,
	input wire logic scan_end_i,
	input wire logic host_we_i,
	input wire logic [WTPU_ADDR_W-1:0] host_addr_i,
	input wire logic [WTPU_DATA_W-1:0] host_wdata_i,
	output logic [WTPU_DATA_W-1:0] host_rdata_o,
	output logic busy_o,
	output logic done_o,
	output logic table_limit_flag_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WTPU_DATA_W-1:0] out_data_o
);
	wtpu_reg_t r, next_r; // engine state and next value
	logic [WTPU_DATA_W-1:0] mem [MEM_WORDS]; // word-addressed data memory
	logic mem_we; // memory write strobe
	logic [WTPU_ADDR_W-1:0] mem_wa; // memory write address
	logic [WTPU_DATA_W-1:0] mem_wd; // memory write data
	logic fifo_in_ready; // popped-word buffer has room
	logic [WTPU_DATA_W-1:0] len_w; // length widened to word size

	// address of a table slot relative to the base
	function automatic logic [WTPU_ADDR_W-1:0] slot(
		input logic [WTPU_ADDR_W-1:0] base,
		input logic [WTPU_ADDR_W-1:0] idx
	);
		return base + idx;
	endfunction

	// memory word at an address
	function automatic logic [WTPU_DATA_W-1:0] rd_word(
		input logic [WTPU_ADDR_W-1:0] a
	);
		return mem[a];
	endfunction

	assign len_w = WTPU_DATA_W'(r.req.len);

	// engine sequencing and memory write selection
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		// host read port, registered
		next_r.rdata = rd_word(host_addr_i);
		// scan end drops the flag; a set later in this process wins
		if (scan_end_i) begin
			next_r.flag = 1'b0;
		end
		unique case (r.state)
			WTPU_IDLE: begin
				// one accepted request per strobe; strobes are not queued
				if (exec_i) begin
					next_r.req = req_i;
					next_r.flag = 1'b0;
					next_r.busy = 1'b1;
					next_r.state = WTPU_FETCH;
				end else if (host_we_i) begin
					// program presets counter and table words
					mem_we = 1'b1;
					mem_wa = host_addr_i;
					mem_wd = host_wdata_i;
				end
			end
			WTPU_FETCH: begin
				// counter lives in the base word
				next_r.cnt = rd_word(slot(r.req.base, WTPU_CNT_OFS));
				next_r.state = WTPU_CHECK;
			end
			WTPU_CHECK: begin
				if (r.req.op == WTPU_OP_POP) begin
					if (r.cnt == WTPU_CNT_EMPTY || r.cnt > len_w) begin
						// nothing moves, counter untouched
						next_r.flag = 1'b1;
						next_r.busy = 1'b0;
						next_r.done = 1'b1;
						next_r.state = WTPU_IDLE;
					end else begin
						// capture entry one before the shift overwrites it
						next_r.word = rd_word(slot(r.req.base, WTPU_TOP_OFS));
						next_r.idx = WTPU_TOP_OFS;
						next_r.state = WTPU_SHIFT;
					end
				end else begin
					if (r.cnt == WTPU_CNT_EMPTY || r.cnt >= len_w) begin
						// full or bad counter: no move, flag at full
						next_r.flag = (r.cnt >= len_w);
						next_r.busy = 1'b0;
						next_r.done = 1'b1;
						next_r.state = WTPU_IDLE;
					end else begin
						// start moving from the lowest live entry
						next_r.idx = WTPU_ADDR_W'(r.cnt);
						next_r.state = WTPU_SHIFT;
					end
				end
			end
			WTPU_SHIFT: begin
				if (r.req.op == WTPU_OP_POP) begin
					if (r.idx < WTPU_ADDR_W'(r.cnt)) begin
						// entry idx+1 moves up to idx; stops at counter
						mem_we = 1'b1;
						mem_wa = slot(r.req.base, r.idx);
						mem_wd = rd_word(slot(r.req.base, r.idx + WTPU_ADDR_STEP));
						next_r.idx = r.idx + WTPU_ADDR_STEP;
					end else begin
						next_r.state = WTPU_EMIT;
					end
				end else begin
					if (r.idx != '0) begin
						// entry idx moves down to idx+1, bottom first
						mem_we = 1'b1;
						mem_wa = slot(r.req.base, r.idx + WTPU_ADDR_STEP);
						mem_wd = rd_word(slot(r.req.base, r.idx));
						next_r.idx = r.idx - WTPU_ADDR_STEP;
					end else begin
						// source word lands in entry one
						mem_we = 1'b1;
						mem_wa = slot(r.req.base, WTPU_TOP_OFS);
						mem_wd = rd_word(r.req.arg);
						next_r.state = WTPU_COUNT;
					end
				end
			end
			WTPU_EMIT: begin
				// popped word to destination and to the stream
				mem_we = 1'b1;
				mem_wa = r.req.arg;
				mem_wd = r.word;
				next_r.emit_v = 1'b1;
				next_r.state = WTPU_HOLD;
			end
			WTPU_HOLD: begin
				// full buffer stalls the engine here
				if (fifo_in_ready) begin
					next_r.emit_v = 1'b0;
					next_r.state = WTPU_COUNT;
				end
			end
			WTPU_COUNT: begin
				mem_we = 1'b1;
				mem_wa = slot(r.req.base, WTPU_CNT_OFS);
				if (r.req.op == WTPU_OP_POP) begin
					mem_wd = r.cnt - WTPU_CNT_STEP;
					next_r.flag = (r.cnt == WTPU_CNT_STEP);
				end else begin
					mem_wd = r.cnt + WTPU_CNT_STEP;
					next_r.flag = ((r.cnt + WTPU_CNT_STEP) == len_w);
				end
				// operation closes before the next strobe is taken
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				next_r.state = WTPU_IDLE;
			end
		endcase
	end

	// engine state register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// data memory write port
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// popped words leave through a small buffer
	wtpu_fifo #(
		.WIDTH(WTPU_DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(r.emit_v),
		.in_ready_o(fifo_in_ready),
		.in_data_i(r.word),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o(out_data_o)
	);

	// registered outputs
	assign host_rdata_o = r.rdata;
	assign busy_o = r.busy;
	assign done_o = r.done;
	assign table_limit_flag_o = r.flag;
endmodule // wtpu_unit

// ==== verif/wtpu_unit_asserts.sv ====
`timescale 1ns/1ps
// engine handshake, flag and stream checks
module wtpu_unit_chk import wtpu_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic exec_i,
	input wire logic scan_end_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic table_limit_flag_o,
	input wire logic out_valid_o,
	input wire logic out_ready_i,
	input wire logic [WTPU_DATA_W-1:0] out_data_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_take; exec_i && !busy_o |=> busy_o && !table_limit_flag_o; endproperty
	a_take: assert property (p_take) else $error("exec not taken");
	property p_min; exec_i && !busy_o |=> busy_o [*2]; endproperty
	a_min: assert property (p_min) else $error("op too short");
	property p_end; exec_i && !busy_o |-> ##[3:1000] done_o; endproperty
	a_end: assert property (p_end) else $error("op never ends");
	property p_done; done_o |-> !busy_o && $past(busy_o); endproperty
	a_done: assert property (p_done) else $error("done without busy");
	property p_pulse; done_o |=> !done_o; endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_rise; $rose(table_limit_flag_o) |-> done_o; endproperty
	a_rise: assert property (p_rise) else $error("flag set off done");
	property p_clr; scan_end_i && !busy_o |=> !table_limit_flag_o; endproperty
	a_clr: assert property (p_clr) else $error("flag kept");
	property p_stall; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o); endproperty
	a_stall: assert property (p_stall) else $error("stream dropped");
	c_flag: cover property (done_o && table_limit_flag_o);
	c_flow: cover property (out_valid_o && out_ready_i);
	c_scan: cover property (scan_end_i && table_limit_flag_o);
endmodule // wtpu_unit_chk
bind wtpu_unit wtpu_unit_chk u_chk (.*);

// ==== verif/wtpu_seq.sv ====
`timescale 1ns/1ps
// scan sequencer: any number of strobes, then one scan end
module wtpu_seq import wtpu_pkg::*; (
	input wire logic clk_i,
	input wire logic done_i,
	output logic exec_o,
	output wtpu_req_t req_o,
	output logic scan_end_o
);
	initial begin
		exec_o = 1'b0;
		req_o = '0;
		scan_end_o = 1'b0;
	end
	// strobe, then count cycles to done
	task automatic issue(input wtpu_op_t o, input logic [11:0] b, a, output int lat);
		@(posedge clk_i);
		exec_o <= 1'b1;
		req_o <= '{o, 8'h0A, b, a};
		@(posedge clk_i);
		exec_o <= 1'b0;
		req_o <= ~req_o;
		#1 lat = 1;
		while (!done_i && lat < 400) begin
			@(posedge clk_i);
			#1 lat++;
		end
	endtask
	// close the scan
	task automatic end_scan();
		@(posedge clk_i);
		scan_end_o <= 1'b1;
		@(posedge clk_i);
		scan_end_o <= 1'b0;
	endtask
endmodule // wtpu_seq

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench import wtpu_pkg::*;;
	logic clk_i = 1'b0, rst_n_i = 1'b0, exec_i, scan_end_i;
	logic host_we_i = 1'b0, out_ready_i = 1'b0;
	logic busy_o, done_o, table_limit_flag_o, out_valid_o;
	logic [11:0] host_addr_i = 12'h000;
	logic [15:0] host_wdata_i = 16'h0000, host_rdata_o, out_data_o;
	wtpu_req_t req_i;
	int errors = 0, n_checks = 0, lat;
	logic [15:0] q[$];
	always #2 clk_i = ~clk_i;
	wtpu_unit DUT (.*);
	wtpu_seq sq (.clk_i(clk_i), .done_i(done_o), .exec_o(exec_i), .req_o(req_i),
		.scan_end_o(scan_end_i));
	// streamed words
	always @(posedge clk_i) if (out_valid_o && out_ready_i) q.push_back(out_data_o);
	task automatic chk(input logic [15:0] g, e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_i);
		host_we_i <= 1'b1;
		host_addr_i <= a;
		host_wdata_i <= d;
		@(posedge clk_i);
		host_we_i <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [15:0] e);
		@(posedge clk_i);
		host_addr_i <= a;
		repeat (2) @(posedge clk_i);
		#1 chk(host_rdata_o, e);
	endtask
	// nine pops, fifo fills while sink stalls
	task automatic t_pop();
		for (int i = 0; i < 11; i++) wr(12'h100 + 12'(i), i ? 16'h1000 + 16'(i) : 16'h0009);
		sq.issue(WTPU_OP_POP, 12'h100, 12'h300, lat);
		chk(16'(lat), 16'h000F);
		rc(12'h300, 16'h1001);
		rc(12'h101, 16'h1002);
		rc(12'h100, 16'h0008);
		repeat (7) sq.issue(WTPU_OP_POP, 12'h100, 12'h300, lat);
		fork
			sq.issue(WTPU_OP_POP, 12'h100, 12'h300, lat);
			begin
				repeat (30) @(posedge clk_i);
				chk({15'h0000, busy_o}, 16'h0001);
				out_ready_i <= 1'b1;
			end
		join
		repeat (20) @(posedge clk_i);
		chk(16'(q.size()), 16'h0009);
		foreach (q[i]) chk(q[i], 16'h1001 + 16'(i));
		chk({15'h0000, table_limit_flag_o}, 16'h0001);
		rc(12'h100, 16'h0000);
		rc(12'h10A, 16'h100A);
	endtask
	// empty and oversized counters refused
	task automatic t_refuse();
		for (int k = 0; k < 2; k++) begin
			if (k) wr(12'h100, 16'h000B);
			sq.issue(WTPU_OP_POP, 12'h100, 12'h300, lat);
			chk(16'(lat), 16'h0003);
			chk({15'h0000, table_limit_flag_o}, 16'h0001);
			rc(12'h100, k ? 16'h000B : 16'h0000);
			rc(12'h300, 16'h1009);
		end
		sq.end_scan();
		#1 chk({15'h0000, table_limit_flag_o}, 16'h0000);
	endtask
	// pushes up to full, last refused
	task automatic t_push();
		for (int i = 0; i < 8; i++) wr(12'h200 + 12'(i), i ? 16'h2000 + 16'(i) : 16'h0007);
		for (int k = 0; k < 4; k++) begin
			wr(12'h310, 16'hA000 + 16'(k));
			sq.issue(WTPU_OP_PUSH, 12'h200, 12'h310, lat);
			chk(16'(lat), (k == 3) ? 16'h0003 : 16'h000C + 16'(k));
			chk({15'h0000, table_limit_flag_o}, 16'(k >= 2));
			rc(12'h200, 16'h0008 + 16'((k == 3) ? 2 : k));
			rc(12'h201, 16'hA000 + 16'((k == 3) ? 2 : k));
		end
		rc(12'h20A, 16'h2007);
	endtask
	task automatic final_report();
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// watchdog
	initial begin
		#100000;
		errors++;
		final_report();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_pop();
		t_refuse();
		t_push();
		final_report();
	end
endmodule // testbench
